//--- include/aux_regs_pkg.sv
// constants for the auxiliary control/status and status summary registers
package aux_regs_pkg;

  // ---------------------------------------------------------------
  // register addresses in the management space
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_AUX_CTRL_STAT = 5'h1b;
  localparam logic [4:0] ADDR_AUX_SUMMARY   = 5'h19;

  // ---------------------------------------------------------------
  // control/status field positions
  // ---------------------------------------------------------------
  localparam int BIT_RXER_CODE    = 0;
  localparam int BIT_SERIAL_10T   = 1;
  localparam int BIT_SUPER_ISO    = 3;
  localparam int BIT_ABILITY_DET  = 4;
  localparam int BIT_ACK_DETECTED = 5;
  localparam int BIT_ACK_COMPLETE = 6;
  localparam int BIT_AN_COMPLETE  = 7;
  localparam int BIT_AN_RESTART   = 8;
  localparam int BIT_HCD_LSB      = 11;
  localparam int HCD_W            = 5;

  // hcd vector order, low to high
  localparam int HCD_10T_HALF   = 0;
  localparam int HCD_10T_FULL   = 1;
  localparam int HCD_100TX_HALF = 2;
  localparam int HCD_100T4      = 3;
  localparam int HCD_100TX_FULL = 4;

  // ---------------------------------------------------------------
  // summary field positions
  // ---------------------------------------------------------------
  localparam int BIT_JABBER     = 0;
  localparam int BIT_AN_ENABLED = 1;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_AUX_CTRL  = 16'h0000;
  localparam logic [1:0]  RESTART_CYC   = 2'h2;
  localparam logic [1:0]  RESTART_ZERO  = 2'h0;

  typedef enum logic [2:0] {
    AN_OFF,
    AN_ABILITY,
    AN_ACK_DET,
    AN_ACK_CPL,
    AN_DONE
  } an_state_e;

endpackage : aux_regs_pkg

//--- hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // async reset, active high
  input  wire logic pin_in,  // asynchronous pin level
  output logic      level    // filtered level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level = level_ff;

endmodule : pin_sync3

//--- hdl/phy_aux_autoneg_status_regs.sv
// auxiliary phy control/status and status summary registers
// ---------------------------------------------------------------
// Notes on behaviour
// - control bit 0 turns the receive-error code mode off at 0 and on at 1.
// - control bit 1 turns the 10BASE-T serial mode off at 0 and on at 1.
// - bit 3 set makes the device ignore mii inputs and float mii outputs, clearing restores.
// - while super isolate is on, no link pulses are transmitted.
// - bit 4 reads 1 exactly while negotiation sits in ability detect.
// - ability detect is entered when negotiation begins and left on the first partner pulses.
// - bit 5 latches when the ack-detected state is left and holds until restart or reset.
// - bit 6 sets when the ack-complete state is left and holds until restart, fault, disable, reset.
// - bit 7 reads 1 after negotiation completes, 0 while running or disabled.
// - writing 1 to bit 8 restarts negotiation from any state and the bit self-clears, reading 0.
// - the bit 8 restart acts exactly like the restart bit of the standard control register.
// - a restart only acts while negotiation is enabled.
// - bits 11 to 15 report the resolved common mode, one bit per mode.
// - the summary register carries a copy of the negotiation enable held elsewhere and its own latched jabber bit.
// - summary bit 0 reads 1 after jabber and clears after one read or reset.
// - jabber is reported only while running 10BASE-T.
// ---------------------------------------------------------------
`timescale 1ns/1ps
module phy_aux_autoneg_status_regs
  import aux_regs_pkg::*;
(
  input  wire logic                    clk,              // 200 MHz clock
  input  wire logic                    rst,              // async reset, active high
  input  wire logic [4:0]              mgmt_addr,        // management register address
  input  wire logic                    mgmt_wr,          // write strobe
  input  wire logic                    mgmt_rd,          // read strobe
  input  wire logic [15:0]             mgmt_wdata,       // write data
  output logic      [15:0]             mgmt_rdata,       // read data, registered
  output logic                         mgmt_rvalid,      // read data valid pulse
  input  wire logic                    an_enable,        // negotiation enable from control reg
  input  wire logic                    std_restart,      // restart pulse from control reg
  input  wire logic                    partner_pulse,    // partner flp/link pulse pin
  input  wire logic                    ack_seen,         // arbiter leaves ack detected
  input  wire logic                    ack_exchange_done,// arbiter leaves ack complete
  input  wire logic                    link_fault,       // link fault event
  input  wire logic [aux_regs_pkg::HCD_W-1:0] hcd_result,// resolved mode, one-hot
  input  wire logic                    jabber_event,     // jabber condition pulse
  input  wire logic                    mode_10t,         // running 10BASE-T
  output logic                         rxer_code_mode,   // receive-error code mode
  output logic                         serial_10t_mode,  // 10BASE-T serial mode
  output logic                         mii_out_en,       // mii outputs driven
  output logic                         mii_in_en,        // mii inputs accepted
  output logic                         link_pulse_en,    // link pulse transmit allowed
  output logic                         an_restart_req    // restart towards negotiation core
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  an_state_e             state_ff;
  an_state_e             nxt_state;
  logic [15:0]           ctrl_ff;
  logic [1:0]            rst_cnt_ff;
  logic                  ack_det_ff;
  logic                  ack_cpl_ff;
  logic [HCD_W-1:0]      hcd_ff;
  logic                  jabber_ff;
  logic                  pulse_prev_ff;
  logic [15:0]           rdata_ff;
  logic                  rvalid_ff;
  logic                  rxer_ff;
  logic                  ser_ff;
  logic                  out_en_ff;
  logic                  in_en_ff;
  logic                  lp_en_ff;
  logic                  restart_out_ff;
  logic                  an_en_prev_ff;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction : hit

  wire        wr_ctrl     = mgmt_wr && hit(mgmt_addr, ADDR_AUX_CTRL_STAT);
  wire        rd_summary  = mgmt_rd && hit(mgmt_addr, ADDR_AUX_SUMMARY);
  wire        rd_ctrl     = mgmt_rd && hit(mgmt_addr, ADDR_AUX_CTRL_STAT);
  wire        aux_restart = wr_ctrl && mgmt_wdata[BIT_AN_RESTART];
  wire        restart_go  = an_enable && (aux_restart || std_restart);
  wire        restart_act = an_enable && (rst_cnt_ff != RESTART_ZERO);
  wire        level_pulse;
  wire        pulse_rise  = level_pulse && !pulse_prev_ff;
  wire        an_begin    = an_enable && !an_en_prev_ff;
  wire        leave_ackd  = (state_ff == AN_ACK_DET) && (nxt_state != AN_ACK_DET)
                            && !restart_act;
  wire        leave_ackc  = (state_ff == AN_ACK_CPL) && (nxt_state == AN_DONE);
  wire        jab_set     = jabber_event && mode_10t;
  wire        iso         = ctrl_ff[BIT_SUPER_ISO];

  // writable control bits only; status and restart never stored
  wire [15:0] ctrl_mask   = (16'h0001 << BIT_RXER_CODE) | (16'h0001 << BIT_SERIAL_10T)
                            | (16'h0001 << BIT_SUPER_ISO);

  wire [15:0] ctrl_view   = (ctrl_ff & ctrl_mask)
                            | ({15'h0000, state_ff == AN_ABILITY} << BIT_ABILITY_DET)
                            | ({15'h0000, ack_det_ff} << BIT_ACK_DETECTED)
                            | ({15'h0000, ack_cpl_ff} << BIT_ACK_COMPLETE)
                            | ({15'h0000, state_ff == AN_DONE} << BIT_AN_COMPLETE)
                            | ({11'h000, hcd_ff} << BIT_HCD_LSB);
  wire [15:0] sum_view    = ({15'h0000, jabber_ff} << BIT_JABBER)
                            | ({15'h0000, an_enable} << BIT_AN_ENABLED);
  wire [15:0] rd_mux      = rd_ctrl ? ctrl_view : (rd_summary ? sum_view : 16'h0000);

  // ---------------------------------------------------------------
  // partner pulse pin
  // ---------------------------------------------------------------
  pin_sync3 u_pulse_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_in (partner_pulse),
    .level  (level_pulse)
  );

  // ---------------------------------------------------------------
  // negotiation sequencing
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (!an_enable) begin
      nxt_state = AN_OFF;
    end else if (restart_act || an_begin) begin
      nxt_state = AN_ABILITY;
    end else begin
      case (state_ff)
        AN_OFF:     nxt_state = AN_ABILITY;
        AN_ABILITY: if (pulse_rise) begin
          nxt_state = AN_ACK_DET;
        end
        AN_ACK_DET: if (ack_seen) begin
          nxt_state = AN_ACK_CPL;
        end
        AN_ACK_CPL: if (ack_exchange_done) begin
          nxt_state = AN_DONE;
        end
        AN_DONE:    nxt_state = AN_DONE;
        default:    nxt_state = AN_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff      <= AN_OFF;
      pulse_prev_ff <= 1'b0;
      an_en_prev_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      pulse_prev_ff <= level_pulse;
      an_en_prev_ff <= an_enable;
    end
  end

  // restart held a few cycles, never visible on read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt_ff <= RESTART_ZERO;
    end else if (restart_go) begin
      rst_cnt_ff <= RESTART_CYC;
    end else if (rst_cnt_ff != RESTART_ZERO) begin
      rst_cnt_ff <= rst_cnt_ff - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // latched status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_det_ff <= 1'b0;
    end else if (restart_act) begin
      ack_det_ff <= 1'b0;
    end else if (leave_ackd) begin
      ack_det_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_cpl_ff <= 1'b0;
    end else if (restart_act || link_fault || !an_enable) begin
      ack_cpl_ff <= 1'b0;
    end else if (leave_ackc) begin
      ack_cpl_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcd_ff <= '0;
    end else if (restart_act || !an_enable) begin
      hcd_ff <= '0;
    end else if (leave_ackc) begin
      hcd_ff <= hcd_result;
    end
  end

  // a jabber in the read cycle survives the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jabber_ff <= 1'b0;
    end else if (jab_set) begin
      jabber_ff <= 1'b1;
    end else if (rd_summary) begin
      jabber_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control register and management read
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= RST_AUX_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= mgmt_wdata & ctrl_mask;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= rd_mux;
      rvalid_ff <= mgmt_rd;
    end
  end

  // ---------------------------------------------------------------
  // mode outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxer_ff        <= 1'b0;
      ser_ff         <= 1'b0;
      out_en_ff      <= 1'b1;
      in_en_ff       <= 1'b1;
      lp_en_ff       <= 1'b1;
      restart_out_ff <= 1'b0;
    end else begin
      rxer_ff        <= ctrl_ff[BIT_RXER_CODE];
      ser_ff         <= ctrl_ff[BIT_SERIAL_10T];
      out_en_ff      <= !iso;
      in_en_ff       <= !iso;
      lp_en_ff       <= !iso;
      restart_out_ff <= restart_act;
    end
  end

  assign mgmt_rdata      = rdata_ff;
  assign mgmt_rvalid     = rvalid_ff;
  assign rxer_code_mode  = rxer_ff;
  assign serial_10t_mode = ser_ff;
  assign mii_out_en      = out_en_ff;
  assign mii_in_en       = in_en_ff;
  assign link_pulse_en   = lp_en_ff;
  assign an_restart_req  = restart_out_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_iso_write;
    wr_ctrl && mgmt_wdata[BIT_SUPER_ISO];
  endsequence
  sequence s_iso_applied;
    ##2 (!mii_out_en && !mii_in_en);
  endsequence

  a_iso_floats_mii: assert property (s_iso_write |-> s_iso_applied)
    else $error("super isolate did not float mii");
  a_iso_no_pulses: assert property (iso |=> !link_pulse_en)
    else $error("link pulses allowed while isolated");
  a_ability_read: assert property (mgmt_rd && rd_ctrl |=>
      mgmt_rdata[BIT_ABILITY_DET] == ($past(state_ff) == AN_ABILITY))
    else $error("ability bit mismatch");
  a_ability_leave: assert property ((state_ff == AN_ABILITY) && pulse_rise && an_enable
      && !restart_act |=> state_ff == AN_ACK_DET)
    else $error("ability detect not left on pulse");
  a_ackdet_hold: assert property (ack_det_ff && !restart_act |=> ack_det_ff)
    else $error("ack detected dropped early");
  a_ackcpl_fault: assert property (link_fault |=> !ack_cpl_ff)
    else $error("ack complete kept over fault");
  a_done_disabled: assert property (!an_enable |=> state_ff != AN_DONE)
    else $error("complete while disabled");
  a_restart_reads0: assert property (rd_ctrl |=> !mgmt_rdata[BIT_AN_RESTART])
    else $error("restart bit read as one");
  a_restart_hold: assert property (restart_go |=> restart_act [*2] ##1 an_restart_req)
    else $error("restart not held");
  // a count still running down from an earlier restart is legal; only a reload is not
  a_restart_gated: assert property (!an_enable && (std_restart || aux_restart)
      |=> rst_cnt_ff != RESTART_CYC)
    else $error("restart acted while disabled");
  a_jabber_clear: assert property (rd_summary && !jab_set |=> !jabber_ff)
    else $error("jabber not cleared by read");
  a_jabber_10t: assert property (jabber_event && !mode_10t && !jabber_ff |=> !jabber_ff)
    else $error("jabber outside 10BASE-T");
  a_ro_ignored: assert property (wr_ctrl |=> (ctrl_ff & ~ctrl_mask) == 16'h0000)
    else $error("read-only bit stored");

endmodule : phy_aux_autoneg_status_regs

//--- testbench/mgmt_master.sv
// station management master model driving the register strobes
`timescale 1ns/1ps
module mgmt_master (
  input  wire logic        clk,         // system clock
  output logic [4:0]       mgmt_addr,   // register address
  output logic             mgmt_wr,     // write strobe
  output logic             mgmt_rd,     // read strobe
  output logic [15:0]      mgmt_wdata,  // write data
  input  wire logic [15:0] mgmt_rdata,  // read data
  input  wire logic        mgmt_rvalid  // read data valid
);
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // released lines flip so a stale value never passes for a live one
  task automatic release_bus();
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_addr  = ~mgmt_addr;
    mgmt_wdata = ~mgmt_wdata;
  endtask : release_bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    @(negedge clk);
    release_bus();
  endtask : wr

  // answer is looked for only in a bounded number of cycles
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(negedge clk);
    release_bus();
    ok = 1'b0;
    d  = 16'h0000;
    for (int n = 0; n < 4 && ok !== 1'b1; n++) begin
      if (mgmt_rvalid === 1'b1) begin
        d  = mgmt_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask : rd
endmodule : mgmt_master

//--- testbench/testbench.sv
// self-checking bench for the auxiliary control and summary registers
`timescale 1ns/1ps
module testbench;
  import aux_regs_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [4:0]        mgmt_addr;
  logic              mgmt_wr, mgmt_rd, mgmt_rvalid;
  logic [15:0]       mgmt_wdata, mgmt_rdata;
  logic              an_enable = 1'b0;
  logic              partner_pulse = 1'b0;
  logic              mode_10t = 1'b0;
  logic [HCD_W-1:0]  hcd_result = '0;
  // event pulses: ack seen, ack done, fault, jabber, std restart
  logic [4:0]        ev = 5'h00;
  logic              rxer_code_mode, serial_10t_mode, mii_out_en;
  logic              mii_in_en, link_pulse_en, an_restart_req;
  int                fails = 0;
  int                check_count = 0;

  always #2.5 clk = ~clk;

  mgmt_master u_mgmt_master (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid));

  phy_aux_autoneg_status_regs u_phy_aux_autoneg_status_regs (.clk(clk), .rst(rst),
    .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .an_enable(an_enable),
    .std_restart(ev[4]), .partner_pulse(partner_pulse), .ack_seen(ev[0]),
    .ack_exchange_done(ev[1]), .link_fault(ev[2]), .hcd_result(hcd_result),
    .jabber_event(ev[3]), .mode_10t(mode_10t), .rxer_code_mode(rxer_code_mode),
    .serial_10t_mode(serial_10t_mode), .mii_out_en(mii_out_en), .mii_in_en(mii_in_en),
    .link_pulse_en(link_pulse_en), .an_restart_req(an_restart_req));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_mgmt_master.rd(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t: read answer missing", $time);
      end_sim();
    end else begin
      check(d, exp);
    end
  endtask : rd_chk

  task automatic pins_chk(input logic [15:0] exp);
    check({11'h000, rxer_code_mode, serial_10t_mode, mii_out_en, mii_in_en, link_pulse_en},
          exp);
  endtask : pins_chk

  task automatic pulse(input int k);
    @(negedge clk);
    ev[k] = 1'b1;
    @(negedge clk);
    ev[k] = 1'b0;
  endtask : pulse

  // restart from either source, counting request cycles
  task automatic restart(input logic via_reg, input logic [15:0] exp_cnt);
    logic [15:0] n;
    if (via_reg) begin
      u_mgmt_master.wr(ADDR_AUX_CTRL_STAT, 16'h0100);
    end else begin
      pulse(4);
    end
    n = 16'h0000;
    repeat (6) begin
      @(negedge clk);
      if (an_restart_req === 1'b1) n++;
    end
    check(n, exp_cnt);
  endtask : restart

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("ERROR %0t: run did not finish", $time);
    end_sim();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    pins_chk(16'h0007);
    rd_chk(ADDR_AUX_CTRL_STAT, RST_AUX_CTRL);
    rd_chk(5'h00, 16'h0000);
    $display("test reset done");
    u_mgmt_master.wr(ADDR_AUX_SUMMARY, 16'hffff);
    u_mgmt_master.wr(ADDR_AUX_CTRL_STAT, 16'hffff);
    repeat (2) @(negedge clk);
    pins_chk(16'h0018);
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h000b);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0000);
    u_mgmt_master.wr(ADDR_AUX_CTRL_STAT, 16'h0000);
    repeat (2) @(negedge clk);
    pins_chk(16'h0007);
    $display("test modes done");
    restart(1'b0, 16'h0000);
    an_enable = 1'b1;
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h0010);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0002);
    for (int i = 0; i < HCD_W; i++) begin
      restart(i[0], {14'h0000, RESTART_CYC});
      rd_chk(ADDR_AUX_CTRL_STAT, 16'h0010);
      hcd_result = {{(HCD_W-1){1'b0}}, 1'b1} << i;
      partner_pulse = 1'b1;
      repeat (6) @(negedge clk);
      partner_pulse = 1'b0;
      rd_chk(ADDR_AUX_CTRL_STAT, 16'h0000);
      pulse(0);
      rd_chk(ADDR_AUX_CTRL_STAT, 16'h0020);
      pulse(1);
      rd_chk(ADDR_AUX_CTRL_STAT, 16'h00e0 | (16'h0001 << (BIT_HCD_LSB + i)));
    end
    $display("test negotiation done");
    pulse(2);
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h80a0);
    an_enable = 1'b0;
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h0020);
    restart(1'b1, 16'h0000);
    restart(1'b0, 16'h0000);
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h0020);
    $display("test disable done");
    mode_10t = 1'b1;
    pulse(3);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0001);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0000);
    mode_10t = 1'b0;
    pulse(3);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0000);
    $display("test jabber done");
    // second reset in mid-run: a pending jabber and the modes must not survive it
    u_mgmt_master.wr(ADDR_AUX_CTRL_STAT, 16'h000b);
    mode_10t = 1'b1;
    pulse(3);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    mode_10t = 1'b0;
    pins_chk(16'h0007);
    rd_chk(ADDR_AUX_SUMMARY, 16'h0000);
    rd_chk(ADDR_AUX_CTRL_STAT, 16'h0000);
    $display("test reset again done");
    end_sim();
  end
endmodule : testbench
